// ---- rtl/osdp_pkg.sv ----
// Package: constants and types for the OSD preamp serial access port
package osdp_pkg;
   // Slave address and direction bit
   localparam logic [6:0] OSDP_SLAVE_ADDR = 7'h5d;
   localparam logic [7:0] OSDP_WRITE_BYTE = 8'hba;
   localparam logic [7:0] OSDP_READ_BYTE = 8'hbb;
   localparam int OSDP_DIR_BIT = 0;
   // Address map
   localparam logic [15:0] OSDP_FONT2_LO = 16'h0000;
   localparam logic [15:0] OSDP_FONT2_HI = 16'h2fff;
   localparam logic [15:0] OSDP_FONT4_LO = 16'h3000;
   localparam logic [15:0] OSDP_FONT4_HI = 16'h3fff;
   localparam logic [15:0] OSDP_PAGE_LO = 16'h8000;
   localparam logic [15:0] OSDP_PAGE_HI = 16'h81ff;
   localparam logic [15:0] OSDP_PLANE_SEL_ADDR = 16'h8402;
   localparam logic [7:0] OSDP_PLANE_SEL_RESET = 8'h00;
   localparam int OSDP_PAGE_DEPTH = 512;
   // Font address fields
   localparam int OSDP_CHAR_MSB = 13;
   localparam int OSDP_CHAR_LSB = 6;
   localparam int OSDP_ROW_MSB = 5;
   localparam int OSDP_ROW_LSB = 1;
   localparam int OSDP_HALF_BIT = 0;
   localparam logic [7:0] OSDP_CHAR2_MAX = 8'hbf;
   localparam logic [7:0] OSDP_CHAR4_MIN = 8'hc0;
   localparam logic [4:0] OSDP_ROW_MAX = 5'h11;
   localparam logic [3:0] OSDP_HIGH_MASK = 4'hf;
   // Bus state
   typedef enum logic [2:0] {
      OSDP_IDLE = 3'b000,
      OSDP_RX = 3'b001,
      OSDP_ACK = 3'b010,
      OSDP_TX = 3'b011,
      OSDP_TXACK = 3'b100,
      OSDP_IGNORE = 3'b101
   } osdp_state_t;
   // Font ROM lookup request; the answer is a plain 12-bit line
   typedef struct packed {
      logic [7:0] char_code;
      logic [4:0] row;
      logic half;
      logic plane;
   } osdp_font_req_t;
   // Serial pins seen by the device
   typedef struct packed {
      logic scl;
      logic sda;
   } osdp_pins_t;
endpackage

// ---- rtl/osdp_access_port.sv ----
// Serial slave access port into the OSD font ROM, page RAM and plane select register
//
// Behaviour
// RULE_01 - Answer only address bytes 0xBA (write) and 0xBB (read).
// RULE_02 - Master opens each transfer with SDA falling while SCL high.
// RULE_03 - Address byte bit 0 is direction, bits 7..1 the slave address.
// RULE_04 - Master releases SDA after each byte; device pulls SDA low to acknowledge.
// RULE_05 - Two register address bytes follow, low byte first, assembled in order.
// RULE_06 - Each acknowledged write byte stored at current address, then address increments.
// RULE_07 - Master sets read address by address-only write and stop first.
// RULE_08 - After read address ack, device shifts out data at loaded address.
// RULE_09 - Address increments after each returned read byte.
// RULE_10 - Master should read only while both display windows are off.
// RULE_11 - 0x0000-0x2FFF two-colour font ROM: char 13..6, row 5..1, half bit 0.
// RULE_12 - 0x3000-0x3FFF four-colour font ROM, codes 0xC0-0xFF, same fields.
// RULE_13 - Low byte pixels 0..7, bit 0 leftmost; high byte bits 3..0 last four.
// RULE_14 - Plane select bit 0 picks four-colour pixel bit 0 or bit 1.
// RULE_15 - 0x8000-0x81FF is 512-entry read/write display page RAM.
// RULE_16 - Writes to font ROM or reserved addresses are acknowledged but dropped.
// RULE_17 - Foreign slave addresses get no acknowledge; SDA stays released afterwards.
`timescale 1ns/1ps
module osdp_access_port #(
   parameter int PAGE_DEPTH = 512,
   parameter int PAGE_WIDTH = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Serial bus, sampled on clk
   input wire osdp_pkg::osdp_pins_t bus_in,
   output logic sda_out,
   output logic sda_oe_n,
   // Font ROM lookup, answered combinationally by the mask ROM outside
   output osdp_pkg::osdp_font_req_t font_req,
   input wire logic [11:0] font_line,
   // Display engine view of the plane select and page RAM activity
   output logic [7:0] plane_select,
   output logic page_write,
   output logic [8:0] page_write_addr,
   output logic [7:0] page_write_data
);
   import osdp_pkg::*;

   osdp_state_t state;
   logic scl_q;
   logic sda_q;
   logic [3:0] bit_cnt;
   logic [7:0] shift;
   logic [1:0] byte_idx;
   logic is_read;
   logic [15:0] reg_addr;
   logic [7:0] tx_byte;
   logic master_nack;
   logic [PAGE_WIDTH-1:0] page_ram [PAGE_DEPTH];
   logic [7:0] read_data;
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic in_font2;
   logic in_font4;
   logic in_page;
   logic [7:0] next_shift;

   // Bus conditions; inputs are already synchronous to clk
   assign scl_rise = bus_in.scl && !scl_q;
   assign scl_fall = !bus_in.scl && scl_q;
   assign start_cond = bus_in.scl && scl_q && sda_q && !bus_in.sda; // see RULE_02
   assign stop_cond = bus_in.scl && scl_q && !sda_q && bus_in.sda;
   assign next_shift = {shift[6:0], bus_in.sda};

   // Address decode of the internal space
   assign in_font2 = reg_addr <= OSDP_FONT2_HI; // see RULE_11
   assign in_font4 = reg_addr >= OSDP_FONT4_LO && reg_addr <= OSDP_FONT4_HI; // see RULE_12
   assign in_page = reg_addr >= OSDP_PAGE_LO && reg_addr <= OSDP_PAGE_HI; // see RULE_15

   // Font lookup code, row and half taken straight from the current address; plane from plane_select bit 0
   always_comb begin
      font_req.char_code = reg_addr[OSDP_CHAR_MSB:OSDP_CHAR_LSB]; // see RULE_11
      font_req.row = reg_addr[OSDP_ROW_MSB:OSDP_ROW_LSB];
      font_req.half = reg_addr[OSDP_HALF_BIT];
      font_req.plane = plane_select[0]; // see RULE_14
   end

   // Read mux; out-of-range codes or rows read as zero rather than stray ROM words
   always_comb begin
      read_data = 8'h00;
      if ((in_font2 && font_req.char_code <= OSDP_CHAR2_MAX) ||
          (in_font4 && font_req.char_code >= OSDP_CHAR4_MIN)) begin
         if (font_req.row <= OSDP_ROW_MAX) begin
            if (!font_req.half) begin
               read_data = font_line[7:0]; // see RULE_13
            end else begin
               read_data = {4'h0, font_line[11:8] & OSDP_HIGH_MASK}; // see RULE_13
            end
         end
      end else if (in_page) begin
         read_data = page_ram[reg_addr[8:0]][7:0]; // see RULE_15
      end else if (reg_addr == OSDP_PLANE_SEL_ADDR) begin
         read_data = plane_select;
      end
   end

   // Edge history of the pins
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= bus_in.scl;
         sda_q <= bus_in.sda;
      end
   end

   // Protocol state machine; a start or stop anywhere aborts the byte in flight
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= OSDP_IDLE;
         bit_cnt <= 4'h0;
         shift <= 8'h00;
         byte_idx <= 2'h0;
         is_read <= 1'b0;
         master_nack <= 1'b0;
      end else if (start_cond) begin
         state <= OSDP_RX;
         bit_cnt <= 4'h0;
         byte_idx <= 2'h0;
      end else if (stop_cond) begin
         state <= OSDP_IDLE;
      end else begin
         case (state)
            OSDP_IDLE: begin
               state <= OSDP_IDLE;
            end
            OSDP_RX: begin
               if (scl_rise) begin
                  shift <= next_shift;
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (scl_fall && bit_cnt == 4'h8) begin
                  bit_cnt <= 4'h0;
                  if (byte_idx == 2'h0) begin
                     // Address byte: whole byte matched against both codes
                     if (shift == OSDP_WRITE_BYTE || shift == OSDP_READ_BYTE) begin // see RULE_01
                        is_read <= shift[OSDP_DIR_BIT]; // see RULE_03
                        state <= OSDP_ACK;
                     end else begin
                        state <= OSDP_IGNORE; // see RULE_17
                     end
                  end else begin
                     state <= OSDP_ACK;
                  end
               end
            end
            OSDP_ACK: begin
               // Acknowledge held across one full SCL pulse
               if (scl_fall) begin
                  if (byte_idx != 2'h3) begin
                     byte_idx <= byte_idx + 2'h1;
                  end
                  state <= (byte_idx == 2'h0 && is_read) ? OSDP_TX : OSDP_RX; // see RULE_08
               end
            end
            OSDP_TX: begin
               if (scl_rise) begin
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (scl_fall && bit_cnt == 4'h8) begin
                  bit_cnt <= 4'h0;
                  state <= OSDP_TXACK;
               end
            end
            OSDP_TXACK: begin
               if (scl_rise) begin
                  master_nack <= bus_in.sda;
               end else if (scl_fall) begin
                  // Master NACK ends the read; wait for stop with SDA released
                  state <= master_nack ? OSDP_IGNORE : OSDP_TX;
               end
            end
            OSDP_IGNORE: begin
               state <= OSDP_IGNORE; // see RULE_17
            end
            default: begin
               state <= OSDP_IDLE;
            end
         endcase
      end
   end

   // Internal address: assembled low byte first, then stepped per data byte
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reg_addr <= 16'h0000;
      end else if (state == OSDP_ACK && scl_fall && !is_read) begin
         if (byte_idx == 2'h1) begin
            reg_addr[7:0] <= shift; // see RULE_05
         end else if (byte_idx == 2'h2) begin
            reg_addr[15:8] <= shift; // see RULE_05
         end else if (byte_idx == 2'h3) begin
            reg_addr <= reg_addr + 16'h0001; // see RULE_06
         end
      end else if (state == OSDP_TX && scl_fall && bit_cnt == 4'h8) begin
         // Stepped as the last bit leaves, so the next byte is ready when the ack slot ends
         reg_addr <= reg_addr + 16'h0001; // see RULE_09
      end
   end

   // Write of a data byte at the start of its acknowledge slot
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         plane_select <= OSDP_PLANE_SEL_RESET;
         page_write <= 1'b0;
         page_write_addr <= 9'h000;
         page_write_data <= 8'h00;
      end else begin
         page_write <= 1'b0;
         if (state == OSDP_RX && scl_fall && bit_cnt == 4'h8 && byte_idx == 2'h3) begin
            // ROM and reserved targets fall through: byte acked, data dropped
            if (in_page) begin // see RULE_16
               page_write <= 1'b1; // see RULE_06
               page_write_addr <= reg_addr[8:0];
               page_write_data <= shift;
            end else if (reg_addr == OSDP_PLANE_SEL_ADDR) begin
               plane_select <= shift; // see RULE_14
            end
         end
      end
   end

   // Page RAM array; no reset, contents are defined by software
   always_ff @(posedge clk) begin
      if (page_write) begin
         page_ram[page_write_addr] <= page_write_data[PAGE_WIDTH-1:0];
      end
   end

   // Transmit byte loaded on entry to each read byte
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tx_byte <= 8'h00;
      end else if ((state == OSDP_ACK || state == OSDP_TXACK) && scl_fall) begin
         tx_byte <= read_data; // see RULE_08
      end else if (state == OSDP_TX && scl_fall) begin
         tx_byte <= {tx_byte[6:0], 1'b0};
      end
   end

   // SDA drive: low pull only, enable low while driving; registered against glitches
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sda_oe_n <= 1'b1;
      end else if (start_cond || stop_cond) begin
         sda_oe_n <= 1'b1;
      end else if (state == OSDP_RX && scl_fall && bit_cnt == 4'h8) begin
         // Ack only our own address; data bytes always acked
         sda_oe_n <= !(byte_idx != 2'h0 ||
                       shift == OSDP_WRITE_BYTE || shift == OSDP_READ_BYTE); // see RULE_04
      end else if (state == OSDP_ACK && scl_fall) begin
         sda_oe_n <= !(byte_idx == 2'h0 && is_read && !read_data[7]);
      end else if (state == OSDP_TX && scl_fall) begin
         sda_oe_n <= (bit_cnt == 4'h8) ? 1'b1 : tx_byte[6];
      end else if (state == OSDP_TXACK && scl_fall) begin
         sda_oe_n <= master_nack ? 1'b1 : read_data[7];
      end
   end

   assign sda_out = 1'b0;
endmodule

// ---- verification/osdp_access_port_properties.sv ----
// Checker: port-level timing properties of the OSD serial access port
`timescale 1ns/1ps
module osdp_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Serial bus
   input wire osdp_pkg::osdp_pins_t bus_in,
   input wire logic sda_out,
   input wire logic sda_oe_n,
   // Display side
   input wire osdp_pkg::osdp_font_req_t font_req,
   input wire logic [7:0] plane_select,
   input wire logic page_write
);
   import osdp_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // Open-drain: the pin value is only ever a pull low
   property p_sda_low; sda_out == 1'b0; endproperty
   a_sda_low: assert property (p_sda_low) else $error("sda_out not low");
   // SDA may only move while SCL is low, or a start or stop would be faked
   property p_oe_scl; $changed(sda_oe_n) |-> !bus_in.scl; endproperty
   a_oe_scl: assert property (p_oe_scl) else $error("SDA moved, SCL high");
   property p_hold; $rose(bus_in.scl) |=> $stable(sda_oe_n)[*3]; endproperty
   a_hold: assert property (p_hold) else $error("SDA not held in SCL high");
   property p_fall;
      $fell(sda_oe_n) |-> !bus_in.scl && ($past(bus_in.scl, 2) || $past(bus_in.scl, 3)
         || $past(bus_in.scl, 4));
   endproperty
   a_fall: assert property (p_fall) else $error("pull late after SCL fall");
   property p_pw_pulse; page_write |=> !page_write; endproperty
   a_pw_pulse: assert property (p_pw_pulse) else $error("page write too long");
   property p_pw_ack; page_write |-> !sda_oe_n && !bus_in.scl; endproperty
   a_pw_ack: assert property (p_pw_ack) else $error("page write outside ack");
   property p_plane; $changed(plane_select) |-> !bus_in.scl; endproperty
   a_plane: assert property (p_plane) else $error("plane changed in SCL high");
   // The lookup address only steps while SCL is low, between bits
   property p_req; $changed(font_req) |-> !bus_in.scl; endproperty
   a_req: assert property (p_req) else $error("font address moved in SCL high");
endmodule
bind osdp_access_port osdp_chk u_chk (.clk(clk), .rstn(rstn), .bus_in(bus_in),
   .sda_out(sda_out), .sda_oe_n(sda_oe_n), .font_req(font_req),
   .plane_select(plane_select), .page_write(page_write));

// ---- verification/osdp_master_model.sv ----
// Master model: drives the controller side of the serial bus
`timescale 1ns/1ps
module osdp_master_model (
   // Clock
   input wire logic clk,
   // Device pull, low while pulling
   input wire logic sda_oe_n,
   // Wire levels
   output osdp_pkg::osdp_pins_t pins
);
   import osdp_pkg::*;
   logic scl = 1'b1;
   logic sda_drv = 1'b1;
   // Pulled-up wire: released level is high, any pull wins
   assign pins = '{scl: scl, sda: sda_drv & sda_oe_n};
   // Five-clock phase; SCL leads on falls and trails on rises, so data never moves in SCL high
   task automatic phase(input logic c, input logic d);
      @(negedge clk);
      if (c) sda_drv = d; else scl = c;
      @(negedge clk);
      if (c) scl = c; else sda_drv = d;
      repeat (3) @(negedge clk);
   endtask
   task automatic start_cond();
      phase(1'b0, 1'b1);
      phase(1'b1, 1'b1);
      phase(1'b1, 1'b0);
   endtask
   task automatic stop_cond();
      phase(1'b0, 1'b0);
      phase(1'b1, 1'b0);
      phase(1'b1, 1'b1);
   endtask
   task automatic bit_io(input logic d, output logic s);
      phase(1'b0, d);
      phase(1'b1, d);
      s = pins.sda;
   endtask
   // MSB first, then SDA released for the acknowledge
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(b[i], s);
      bit_io(1'b1, s);
      ack = ~s;
   endtask
   task automatic recv_byte(input logic mack, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
      bit_io(~mack, s);
   endtask
endmodule

// ---- verification/tb_top.sv ----
// Testbench: register traffic through the master model, with expected values
`timescale 1ns/1ps
module tb_top;
   import osdp_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   int num_errors = 0;
   int cmp_count = 0;
   osdp_pins_t pins;
   osdp_font_req_t font_req;
   logic sda_oe_n, page_write, ack;
   logic [11:0] font_line;
   logic [7:0] plane_select, pw_data, rd;
   logic [8:0] pw_addr;
   logic [16:0] pw_q[$];
   // 20 MHz clock
   initial begin
      forever #25 clk = ~clk;
   end
   osdp_master_model u_mst (.clk(clk), .sda_oe_n(sda_oe_n), .pins(pins));
   osdp_access_port u_dut (.clk(clk), .rstn(rstn), .bus_in(pins), .sda_out(),
      .sda_oe_n(sda_oe_n), .font_req(font_req), .font_line(font_line),
      .plane_select(plane_select), .page_write(page_write),
      .page_write_addr(pw_addr), .page_write_data(pw_data));
   // Font ROM stand-in: each line mixes the code, row and plane bits
   function automatic logic [11:0] rom(input logic [7:0] c, input logic [4:0] r, input logic p);
      return {r[3:0] ^ c[7:4], c ^ {2'h0, r, p}};
   endfunction
   assign font_line = rom(font_req.char_code, font_req.row, font_req.plane);
   // Log of page RAM writes
   always @(posedge clk) begin
      if (page_write === 1'b1) pw_q.push_back({pw_addr, pw_data});
   end
   task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic set_addr(input logic [15:0] a);
      u_mst.start_cond();
      u_mst.send_byte(OSDP_WRITE_BYTE, ack);
      check("ack wr", 17'(ack), 17'd1);
      u_mst.send_byte(a[7:0], ack);
      check("ack lo", 17'(ack), 17'd1);
      u_mst.send_byte(a[15:8], ack);
      check("ack hi", 17'(ack), 17'd1);
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d0, input logic [7:0] d1);
      set_addr(a);
      u_mst.send_byte(d0, ack);
      check("ack d0", 17'(ack), 17'd1);
      u_mst.send_byte(d1, ack);
      check("ack d1", 17'(ack), 17'd1);
      u_mst.stop_cond();
   endtask
   // Address-only write and stop, then a read of two bytes, the last not acknowledged
   task automatic rd2(input logic [15:0] a, input logic [7:0] e0, input logic [7:0] e1);
      set_addr(a);
      u_mst.stop_cond();
      u_mst.start_cond();
      u_mst.send_byte(OSDP_READ_BYTE, ack);
      check("ack rd", 17'(ack), 17'd1);
      u_mst.recv_byte(1'b1, rd);
      check("rd0", 17'(rd), 17'(e0));
      u_mst.recv_byte(1'b0, rd);
      check("rd1", 17'(rd), 17'(e1));
      u_mst.stop_cond();
   endtask
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      logic [11:0] f;
      repeat (16) @(negedge clk);
      rstn = 1'b1;
      check("plane rst", 17'(plane_select), 17'(OSDP_PLANE_SEL_RESET));
      // Last page entry, then a byte past the end that must be dropped
      wr(16'h81ff, 8'h5a, 8'ha5);
      wr(16'h8000, 8'h11, 8'h22);
      check("pw0", pw_q[0], {9'h1ff, 8'h5a});
      check("pw1", pw_q[1], {9'h000, 8'h11});
      check("pw2", pw_q[2], {9'h001, 8'h22});
      rd2(16'h8000, 8'h11, 8'h22);
      // Two-colour font, last valid row; the write into the ROM is dropped
      wr({2'b00, 8'h12, 5'h11, 1'b0}, 8'hff, 8'hff);
      f = rom(8'h12, 5'h11, 1'b0);
      rd2({2'b00, 8'h12, 5'h11, 1'b0}, f[7:0], {4'h0, f[11:8]});
      // Plane 1 of the last four-colour code
      wr(OSDP_PLANE_SEL_ADDR, 8'h01, 8'h00);
      check("plane", 17'(plane_select), 17'h1);
      rd2(OSDP_PLANE_SEL_ADDR, 8'h01, 8'h00);
      f = rom(8'hff, 5'h00, 1'b1);
      rd2({2'b00, 8'hff, 5'h00, 1'b0}, f[7:0], {4'h0, f[11:8]});
      // Foreign slave address: no acknowledge, SDA left alone afterwards
      u_mst.start_cond();
      u_mst.send_byte(8'hbc, ack);
      check("foreign", 17'(ack), 17'd0);
      u_mst.send_byte(8'h00, ack);
      check("foreign d", 17'(ack), 17'd0);
      u_mst.stop_cond();
      check("pw count", 17'(pw_q.size()), 17'd3);
      complete_run();
   end
   // Watchdog, far beyond the few thousand cycles the sequence needs
   initial begin
      repeat (40000) @(posedge clk);
      num_errors++;
      complete_run();
   end
endmodule
